// ==== pkg/icsd_map.svh ====
`ifndef ICSD_MAP_SVH
`define ICSD_MAP_SVH
// ----------------------------------------
// Decode ranges (host I/O byte addresses)
// ----------------------------------------
`define ICSD_ADDR_W 10
`define ICSD_PRI_CMD_BASE 10'h1F0
`define ICSD_SEC_CMD_BASE 10'h170
`define ICSD_CMD_MASK 10'h3F8
`define ICSD_PRI_CTL_BASE 10'h3F6
`define ICSD_SEC_CTL_BASE 10'h376
`define ICSD_CTL_MASK 10'h3FE
`define ICSD_XT_BASE 10'h320
`define ICSD_XT_MASK 10'h3FC
// ----------------------------------------
// Reset values
// ----------------------------------------
`define ICSD_STRAP_RST 4'h0
`endif

// ==== pkg/icsd_pkg.sv ====
package icsd_pkg;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	// Strap values latched while reset is held
	typedef struct packed {
		logic serial_addr_strap_hi;
		logic serial_addr_strap_lo;
		logic disk_addr_strap;
		logic floppy_addr_strap;
	} icsd_strap_t;
	// Decoded select outputs, all active low
	typedef struct packed {
		logic low_byte_buf_en_n;
		logic high_byte_buf_en_n;
		logic disk_cs_first_n;
		logic disk_cs_second_n;
	} icsd_sel_t;
	// Reset phase of the strap sampler
	typedef enum logic [0:0] {
		ICSD_ST_STRAP = 1'b0,
		ICSD_ST_RUN = 1'b1
	} icsd_state_t;
endpackage

// ==== tb/icsd_disk_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Disk drive and strap board at the pads
// ----------------------------------------
module icsd_disk_model (
	// Commands from the bench
	input wire logic wide_req_i,
	input wire icsd_pkg::icsd_strap_t board_strap_i,
	// Pads
	input wire icsd_pkg::icsd_sel_t sel_i,
	input wire logic sel_oe_n_i,
	output logic wide_n_o,
	output icsd_pkg::icsd_strap_t pad_o
);
	import icsd_pkg::*;
	// Indicator low only while selected on the data port, else pulled up
	assign wide_n_o = !(wide_req_i && sel_i.disk_cs_first_n === 1'b0);
	// Board drives straps only while the pads float; later it sees drivers
	assign pad_o = sel_oe_n_i ? board_strap_i : icsd_strap_t'(sel_i);
endmodule
`default_nettype wire

// ==== tb/ide_chip_select_decoder_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module ide_chip_select_decoder_test;
	import icsd_pkg::*;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic sys_clk_i = 0, rst_i = 1, io_cycle_i = 0, dma_ack_n_i = 1;
	logic ide_enable_i = 0, at_mode_i = 0, secondary_i = 0, wide_req = 0;
	logic [9:0] io_addr_i = '0;
	logic wide_n, oe_n;
	icsd_strap_t pad, strap_o, board = '0;
	icsd_sel_t sel_o;
	int fails = 0, n_tests = 0, seed = 32'h15fe_9da0;
	// Range edges, one inside and one outside each window
	logic [9:0] corner [16] = '{10'h1ef, 10'h1f0, 10'h1f7, 10'h1f8,
		10'h16f, 10'h170, 10'h177, 10'h3f5, 10'h3f6, 10'h3f7, 10'h376,
		10'h377, 10'h378, 10'h31f, 10'h323, 10'h324};
	// Clock, 100 ns period
	initial forever #50 sys_clk_i = ~sys_clk_i;
	icsd_decoder i_icsd_decoder (.sys_clk_i, .rst_i, .io_addr_i, .io_cycle_i,
		.dma_ack_n_i, .ide_enable_i, .at_mode_i, .secondary_i,
		.wide_xfer_indicator_n_i(wide_n), .strap_pin_i(pad), .sel_o,
		.sel_oe_n_o(oe_n), .strap_o);
	icsd_disk_model i_icsd_disk_model (.wide_req_i(wide_req),
		.board_strap_i(board), .sel_i(sel_o), .sel_oe_n_i(oe_n),
		.wide_n_o(wide_n), .pad_o(pad));
	// ----------------------------------------
	// Expectations and checks
	// ----------------------------------------
	function automatic icsd_sel_t exp_sel(logic [9:0] a,
		logic cyc, dk, en, at, sec, w);
		logic cmd, ctl, xt, six;
		cmd = (a & 10'h3f8) == (sec ? 10'h170 : 10'h1f0);
		ctl = (a & 10'h3fe) == (sec ? 10'h376 : 10'h3f6);
		xt = ((a & 10'h3fc) == 10'h320) && (cyc || !dk);
		six = (a & 10'h3fe) == 10'h3f6;
		exp_sel = '1;
		if (en && at && cyc) exp_sel = '{!(cmd || ctl), !(cmd && w), !cmd, !ctl};
		else if (en && !at) exp_sel = '{!xt, 1'b1, !xt, !(six && cyc)};
	endfunction
	task automatic check(string what, logic [3:0] exp, logic [3:0] got);
		n_tests++;
		if (exp !== got) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Straps held steady through reset, then the board drives their inverse
	task automatic reset_with(icsd_strap_t s);
		@(negedge sys_clk_i);
		rst_i = 1;
		board = s;
		repeat (6) @(negedge sys_clk_i);
		check("oe_n in reset", 4'h1, {3'b0, oe_n});
		check("sel in reset", 4'hf, sel_o);
		rst_i = 0;
		@(negedge sys_clk_i);
		board = ~s;
		check("straps", s, strap_o);
		check("oe_n run", 4'h0, {3'b0, oe_n});
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	// Hold each setting 8 cycles: indicator loop needs two 3-cycle decodes
	initial begin
		reset_with(4'h5);
		for (int i = 0; i < 300; i++) begin
			@(negedge sys_clk_i);
			io_addr_i = i[0] ? corner[{$random(seed)} % 16] : 10'($random(seed));
			{io_cycle_i, dma_ack_n_i, ide_enable_i, at_mode_i, secondary_i,
				wide_req} = 6'($random(seed));
			repeat (8) @(negedge sys_clk_i);
			check("sel", exp_sel(io_addr_i, io_cycle_i, dma_ack_n_i, ide_enable_i, at_mode_i, secondary_i, wide_req), sel_o);
			if (i == 150) reset_with(4'ha);
		end
		complete_run;
	end
	// Run needs about 2700 cycles; give it 5000
	initial begin
		#500_000;
		fails++;
		complete_run;
	end
endmodule
`default_nettype wire

// ==== verilog/icsd_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "icsd_map.svh"
module icsd_decoder (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Host I/O bus
	input wire logic [`ICSD_ADDR_W-1:0] io_addr_i,
	input wire logic io_cycle_i,
	input wire logic dma_ack_n_i,
	// Configuration
	input wire logic ide_enable_i,
	input wire logic at_mode_i,
	input wire logic secondary_i,
	// Disk side
	input wire logic wide_xfer_indicator_n_i,
	// Strap pins, read back from the shared pads
	input wire icsd_pkg::icsd_strap_t strap_pin_i,
	// Pad drivers, enable low while driving
	output icsd_pkg::icsd_sel_t sel_o,
	output logic sel_oe_n_o,
	// Latched straps
	output icsd_pkg::icsd_strap_t strap_o
);
	import icsd_pkg::*;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int SYNC_W = `ICSD_ADDR_W + 6;
	logic [SYNC_W-1:0] raw_in;
	logic [SYNC_W-1:0] syn_in;
	logic [`ICSD_ADDR_W-1:0] addr;
	logic cyc;
	logic dack_n;
	logic ide_en;
	logic at;
	logic sec;
	logic wide_n;
	icsd_strap_t strap_syn;

	// All pins come from the host bus or the board, not this clock.
	// Address bits cross one by one, so a select may show a stray value
	// for one cycle while the host moves the address.
	assign raw_in = {io_addr_i, io_cycle_i, dma_ack_n_i, ide_enable_i,
		at_mode_i, secondary_i, wide_xfer_indicator_n_i};

	icsd_sync2 #(.W(SYNC_W)) u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.d_i(raw_in),
		.q_o(syn_in)
	);

	// Strap sync is never cleared, as it must keep sampling through reset
	icsd_sync2 #(.W(4)) u_sync_strap (
		.sys_clk_i(sys_clk_i),
		.rst_i(1'b0),
		.d_i(strap_pin_i),
		.q_o(strap_syn)
	);

	assign addr = syn_in[SYNC_W-1 -: `ICSD_ADDR_W];
	assign cyc = syn_in[5];
	assign dack_n = syn_in[4];
	assign ide_en = syn_in[3];
	assign at = syn_in[2];
	assign sec = syn_in[1];
	assign wide_n = syn_in[0];

	// ----------------------------------------
	// Strap capture
	// ----------------------------------------
	// Pads are released while reset is held so the board can drive straps.
	// Sampling goes on every cycle of reset and the last value is kept;
	// a strap that moves in the last cycle of reset is missed.
	icsd_state_t state;
	icsd_state_t next_state;
	icsd_strap_t strap_q;
	icsd_strap_t next_strap;

	always_comb begin
		next_state = state;
		next_strap = strap_q;
		unique case (state)
			ICSD_ST_STRAP: begin
				// Latch on every reset cycle
				next_strap = strap_syn;
				if (!rst_i) begin
					next_state = ICSD_ST_RUN;
				end
			end
			ICSD_ST_RUN: begin
				next_state = ICSD_ST_RUN;
			end
		endcase
		if (rst_i) begin
			next_state = ICSD_ST_STRAP;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		state <= next_state;
		strap_q <= next_strap;
	end

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	logic hit_cmd;
	logic hit_ctl;
	logic hit_xt;
	logic hit_xt_ctl;
	icsd_sel_t next_sel;

	always_comb begin
		hit_cmd = (addr & `ICSD_CMD_MASK) ==
			(sec ? `ICSD_SEC_CMD_BASE : `ICSD_PRI_CMD_BASE);
		hit_ctl = (addr & `ICSD_CTL_MASK) ==
			(sec ? `ICSD_SEC_CTL_BASE : `ICSD_PRI_CTL_BASE);
		hit_xt = ((addr & `ICSD_XT_MASK) == `ICSD_XT_BASE) &&
			(cyc || !dack_n);
		hit_xt_ctl = (addr & `ICSD_CTL_MASK) == `ICSD_PRI_CTL_BASE;
		// Inactive by default
		next_sel = '1;
		if (ide_en && state == ICSD_ST_RUN) begin
			if (at) begin
				if (cyc) begin
					// Low byte on both ranges
					next_sel.low_byte_buf_en_n = !(hit_cmd || hit_ctl);
					// High byte gated by 16-bit indicator
					next_sel.high_byte_buf_en_n = !(hit_cmd && !wide_n);
					next_sel.disk_cs_first_n = !hit_cmd;
					next_sel.disk_cs_second_n = !hit_ctl;
				end
			end else begin
				// XT decode; high byte stays off
				next_sel.low_byte_buf_en_n = !hit_xt;
				next_sel.disk_cs_first_n = !hit_xt;
				next_sel.disk_cs_second_n = !(cyc && hit_xt_ctl);
			end
		end
	end

	// Outputs registered; pads float during reset for strap reading
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sel_o <= '1;
			sel_oe_n_o <= 1'b1;
			strap_o <= icsd_strap_t'(`ICSD_STRAP_RST);
		end else begin
			sel_o <= next_sel;
			sel_oe_n_o <= 1'b0;
			strap_o <= strap_q;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	// Last reset edge followed by the first run edge: pad hand-over
	sequence s_release;
		rst_i ##1 !rst_i;
	endsequence

	AST_XT_NO_HIGH: assert property (
		!at |=> sel_o.high_byte_buf_en_n)
		else $error("high byte enable in XT mode");
	AST_OFF_IDLE: assert property (
		!ide_en |=> sel_o == '1)
		else $error("select active with IDE disabled");
	AST_AT_CS0: assert property (
		ide_en && at && cyc && hit_cmd && state == ICSD_ST_RUN
		|=> !sel_o.disk_cs_first_n)
		else $error("first chip select missing in AT");
	AST_AT_CS1: assert property (
		ide_en && at && cyc && hit_ctl && state == ICSD_ST_RUN
		|=> !sel_o.disk_cs_second_n)
		else $error("second chip select missing in AT");
	AST_LO_AT: assert property (
		ide_en && at && cyc && (hit_cmd || hit_ctl) &&
		state == ICSD_ST_RUN |=> !sel_o.low_byte_buf_en_n)
		else $error("low byte enable missing in AT");
	AST_LO_SEC: assert property (
		ide_en && at && sec && cyc && state == ICSD_ST_RUN &&
		(addr & `ICSD_CTL_MASK) == `ICSD_SEC_CTL_BASE
		|=> !sel_o.low_byte_buf_en_n && !sel_o.disk_cs_second_n)
		else $error("low byte enable missing on secondary control");
	AST_HI_GATE: assert property (
		!sel_o.high_byte_buf_en_n |-> $past(!wide_n && at && hit_cmd))
		else $error("high byte enable without 16-bit indicator");
	AST_XT_CS0: assert property (
		ide_en && !at && hit_xt && state == ICSD_ST_RUN
		|=> !sel_o.disk_cs_first_n && !sel_o.low_byte_buf_en_n)
		else $error("XT select missing");
	AST_XT_DMA: assert property (
		ide_en && !at && !dack_n && state == ICSD_ST_RUN &&
		(addr & `ICSD_XT_MASK) == `ICSD_XT_BASE
		|=> !sel_o.low_byte_buf_en_n)
		else $error("low byte enable missing on XT DMA");
	AST_XT_CS1: assert property (
		ide_en && !at && cyc && hit_xt_ctl && state == ICSD_ST_RUN
		|=> !sel_o.disk_cs_second_n)
		else $error("XT second select missing");
	AST_STRAP_HOLD: assert property (
		state == ICSD_ST_RUN |=> $stable(strap_q) && $stable(strap_o))
		else $error("strap changed after reset");
	AST_STRAP_LATCH: assert property (
		state == ICSD_ST_STRAP && !rst_i |=> strap_q == $past(strap_syn))
		else $error("strap not latched at reset release");
	AST_RESET_FLOAT: assert property (disable iff (1'b0)
		rst_i |=> sel_oe_n_o && sel_o == '1)
		else $error("pads driven during reset");
	AST_RELEASE: assert property (disable iff (1'b0)
		s_release |=> !sel_oe_n_o && sel_o == '1 && strap_o == $past(strap_q))
		else $error("pad hand-over wrong after reset");
endmodule
`default_nettype wire

// ==== verilog/icsd_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Two-flop synchroniser, one per bit
// ----------------------------------------
module icsd_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	// First stage feeds only the second stage
	always_comb begin
		next_meta = d_i;
		next_q = meta;
	end

	// Both stages registered
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			meta <= '0;
			q_o <= '0;
		end else begin
			meta <= next_meta;
			q_o <= next_q;
		end
	end
endmodule
`default_nettype wire
